// file: rtl/pmc_consts.svh
// Constants for the power management control register block
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_OFFSET 12'h084
`define PMC_STATE_HI 31
`define PMC_STATE_LO 29
`define PMC_COMMIT_BIT 28
`define PMC_AUTOWAKE_BIT 27
`define PMC_LEDOFF_BIT 26
`define PMC_CLKOFF_BIT 21
`define PMC_FLAG_B_BIT 17
`define PMC_FLAG_A_BIT 16
`define PMC_EN_B_BIT 15
`define PMC_EN_A_BIT 14
`define PMC_READY_BIT 0
`define PMC_STATE_RESET 3'h0
`define PMC_STATE_D0 3'h0
`define PMC_STATE_D3 3'h3
`define PMC_ZERO32 32'h00000000
`define PMC_WAKE_US 2
`define PMC_CLK_MHZ 250

`endif

// file: rtl/pmc_pkg.sv
// Types for the power management control register block
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_AWAKE = 2'b00,
    PMC_ASLEEP = 2'b01,
    PMC_WAKING = 2'b10
  } pmc_phase_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pmc_req_type;

  typedef struct packed {
    logic ready;
    logic asleep;
    logic fieldbus_core_clock_off;
    logic indicator_output_off;
    logic [2:0] sleep_state_select;
  } pmc_stat_type;
endpackage : pmc_pkg

// file: rtl/pmc_ctrl.sv
// Power management control register with sleep and wake sequencing
//
// Behaviour
// - Three-bit sleep state select in 31:29, reset zero, codes 4-7 reserved.
// - Select write dropped when the same write sets the commit bit.
// - Commit bit 28 enters selected state; reads one while asleep.
// - Commit write of one ignored when the same write changes select.
// - Wake-up clears both select field and commit bit.
// - Bit 27 enables automatic wake on power management events, except when select is D3.
// - Bit 26 floats open-drain LEDs and idles push-pull LEDs.
// - Bit 21 gates off all fieldbus core clocks.
// - Bit 21 sets only after two consecutive writes of one.
// - Bit 17 flags port B energy or wake event; host clears.
// - Bit 16 flags port A energy or wake event; host clears.
// - A flag clears only once its event source is also clear.
// - Bit 15 routes port B events to the event interrupt flag.
// - Bit 14 routes port A events to the event interrupt flag.
// - Reads are served during not-ready and sleep states.
// - Partial byte reads are accepted without ordering rules.
// - Ready forced low in sleep, raised after wake settles.
// - Ready rising edge pulses the ready interrupt flag.
// - Any host access wakes the device; writes ignored meanwhile.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_ctrl #(
  parameter int WAKE_CYCLES = `PMC_WAKE_US * `PMC_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire pmc_pkg::pmc_req_type host_req,
  input wire logic pll_locked,
  input wire logic port_a_event,
  input wire logic port_b_event,
  input wire logic ready_ok,
  input wire logic [1:0] led_level,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  output pmc_pkg::pmc_stat_type status,
  output logic pm_event_irq_flag,
  output logic ready_irq_flag,
  output logic [1:0] led_out,
  output logic [1:0] led_oe
);
  import pmc_pkg::*;

  // ********************
  // Input synchronisers
  // ********************
  logic [2:0] sa_r, sb_r, sp_r;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      sa_r <= 3'h0;
      sb_r <= 3'h0;
      sp_r <= 3'h0;
    end
    else if (clk_en)
    begin
      sa_r <= {sa_r[1:0], port_a_event};
      sb_r <= {sb_r[1:0], port_b_event};
      sp_r <= {sp_r[1:0], pll_locked};
    end

  logic ev_a_r, ev_b_r, lock_r;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      ev_a_r <= 1'b0;
      ev_b_r <= 1'b0;
      lock_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sa_r[1] == sa_r[2]) ev_a_r <= sa_r[2];
      if (sb_r[1] == sb_r[2]) ev_b_r <= sb_r[2];
      if (sp_r[1] == sp_r[2]) lock_r <= sp_r[2];
    end

  // ********************
  // Access decode
  // ********************
  function automatic logic hits(input pmc_req_type r);
    hits = r.addr == `PMC_OFFSET;
  endfunction : hits

  pmc_phase_type phase_r;
  logic [2:0] sel_r;
  logic commit_r, autowake_r, ledoff_r, clkoff_r, clk_pend_r;
  logic flag_a_r, flag_b_r, en_a_r, en_b_r, ready_r;
  logic [31:0] wake_cnt_r;

  logic awake, wr_hit;
  logic [2:0] w_sel;
  logic w_commit, sel_new, commit_go;
  assign awake = phase_r == PMC_AWAKE;
  assign wr_hit = host_req.wr && hits(host_req) && awake;
  assign w_sel = host_req.wdata[`PMC_STATE_HI:`PMC_STATE_LO];
  assign w_commit = host_req.wdata[`PMC_COMMIT_BIT] && host_req.be[3];
  assign sel_new = host_req.be[3] && (w_sel != sel_r);
  assign commit_go = wr_hit && w_commit && !sel_new;
  logic sleeps;
  assign sleeps = commit_go && (sel_r <= `PMC_STATE_D3);

  // ********************
  // Power phase
  // ********************
  logic host_touch, auto_ev, wake_done;
  assign host_touch = host_req.wr || host_req.rd;
  assign auto_ev = autowake_r && sel_r != `PMC_STATE_D3 &&
                   ((ev_a_r && en_a_r) || (ev_b_r && en_b_r));
  assign wake_done = wake_cnt_r >= 32'(WAKE_CYCLES) && lock_r;

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      phase_r <= PMC_AWAKE;
    else if (clk_en)
      unique case (phase_r)
        PMC_AWAKE: if (sleeps) phase_r <= PMC_ASLEEP;
        PMC_ASLEEP: if (host_touch || auto_ev) phase_r <= PMC_WAKING;
        PMC_WAKING: if (wake_done) phase_r <= PMC_AWAKE;
        default: phase_r <= PMC_AWAKE;
      endcase

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      wake_cnt_r <= `PMC_ZERO32;
    else if (clk_en)
      wake_cnt_r <= (phase_r == PMC_WAKING && !wake_done) ?
                    wake_cnt_r + 32'h1 : `PMC_ZERO32;

  // ********************
  // Select and commit
  // ********************
  logic leave;
  assign leave = phase_r == PMC_WAKING && wake_done;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      sel_r <= `PMC_STATE_RESET;
      commit_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (leave)
      begin
        sel_r <= `PMC_STATE_RESET;
        commit_r <= 1'b0;
      end
      else if (wr_hit && host_req.be[3])
      begin
        if (!w_commit) sel_r <= w_sel;
        if (sleeps) commit_r <= 1'b1;
      end
    end

  // ********************
  // Plain controls
  // ********************
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      autowake_r <= 1'b0;
      ledoff_r <= 1'b0;
      en_a_r <= 1'b0;
      en_b_r <= 1'b0;
    end
    else if (clk_en && wr_hit)
    begin
      if (host_req.be[3])
      begin
        autowake_r <= host_req.wdata[`PMC_AUTOWAKE_BIT];
        ledoff_r <= host_req.wdata[`PMC_LEDOFF_BIT];
      end
      if (host_req.be[1])
      begin
        en_a_r <= host_req.wdata[`PMC_EN_A_BIT];
        en_b_r <= host_req.wdata[`PMC_EN_B_BIT];
      end
    end

  // Two consecutive ones needed; zero restarts
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      clkoff_r <= 1'b0;
      clk_pend_r <= 1'b0;
    end
    else if (clk_en && wr_hit && host_req.be[2])
    begin
      if (!host_req.wdata[`PMC_CLKOFF_BIT])
      begin
        clk_pend_r <= 1'b0;
        clkoff_r <= 1'b0;
      end
      else if (clk_pend_r)
        clkoff_r <= 1'b1;
      else
        clk_pend_r <= 1'b1;
    end

  // ********************
  // Event flags
  // ********************
  logic clr_a, clr_b;
  assign clr_a = wr_hit && host_req.be[2] && host_req.wdata[`PMC_FLAG_A_BIT];
  assign clr_b = wr_hit && host_req.be[2] && host_req.wdata[`PMC_FLAG_B_BIT];
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ev_a_r) flag_a_r <= 1'b1;
      else if (clr_a) flag_a_r <= 1'b0;
      if (ev_b_r) flag_b_r <= 1'b1;
      else if (clr_b) flag_b_r <= 1'b0;
    end

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      pm_event_irq_flag <= 1'b0;
    else if (clk_en)
      pm_event_irq_flag <= (flag_a_r && en_a_r) ||
                           (flag_b_r && en_b_r);

  // ********************
  // Ready
  // ********************
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      ready_r <= 1'b0;
      ready_irq_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      ready_r <= awake && ready_ok && !sleeps;
      ready_irq_flag <= awake && ready_ok && !sleeps && !ready_r;
    end

  // ********************
  // Read path and outputs
  // ********************
  logic [31:0] word;
  always_comb
  begin
    word = `PMC_ZERO32;
    word[`PMC_STATE_HI:`PMC_STATE_LO] = sel_r;
    word[`PMC_COMMIT_BIT] = commit_r;
    word[`PMC_AUTOWAKE_BIT] = autowake_r;
    word[`PMC_LEDOFF_BIT] = ledoff_r;
    word[`PMC_CLKOFF_BIT] = clkoff_r;
    word[`PMC_FLAG_B_BIT] = flag_b_r;
    word[`PMC_FLAG_A_BIT] = flag_a_r;
    word[`PMC_EN_B_BIT] = en_b_r;
    word[`PMC_EN_A_BIT] = en_a_r;
    word[`PMC_READY_BIT] = ready_r;
  end

  // Reads answered in any phase; disabled lanes read zero
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      host_rdata <= `PMC_ZERO32;
      host_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      host_rvalid <= host_req.rd && hits(host_req);
      host_rdata <= word & {{8{host_req.be[3]}}, {8{host_req.be[2]}},
                            {8{host_req.be[1]}}, {8{host_req.be[0]}}};
    end

  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      status <= '0;
      led_out <= 2'h0;
      led_oe <= 2'h0;
    end
    else if (clk_en)
    begin
      status <= {ready_r, !awake, clkoff_r, ledoff_r, sel_r};
      led_out <= ledoff_r ? 2'h0 : led_level;
      led_oe <= ledoff_r ? 2'h0 : 2'h3;
    end

  // ********************
  // Checks
  // ********************
  sequence s_two_ones;
    wr_hit && host_req.be[2] && host_req.wdata[`PMC_CLKOFF_BIT] &&
    !clk_pend_r && !clkoff_r;
  endsequence

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    host_rvalid |-> host_rdata[25:22] == 4'h0 && host_rdata[13:1] == 13'h0)
    else $error("reserved bits not zero");
  a_commit_sel_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && wr_hit && w_commit && !leave |=> $stable(sel_r))
    else $error("select changed with commit");
  a_commit_new_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && awake && wr_hit && sel_new |=> phase_r == PMC_AWAKE)
    else $error("slept on changed select");
  a_sleep_enter: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && sleeps |=> phase_r == PMC_ASLEEP && commit_r)
    else $error("sleep not entered");
  a_wake_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && leave |=> sel_r == 3'h0 && !commit_r)
    else $error("wake did not clear");
  a_clk_one_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en and s_two_ones |=> !clkoff_r)
    else $error("clock off after one write");
  a_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ev_a_r |=> flag_a_r)
    else $error("port a flag missed");
  a_flag_set_b: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ev_b_r |=> flag_b_r)
    else $error("port b flag missed");
  a_led_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ledoff_r |=> led_oe == 2'h0 && led_out == 2'h0)
    else $error("leds driven while off");
  a_ready_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !awake |=> !ready_r)
    else $error("ready high while asleep");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && host_req.rd && hits(host_req) |=> host_rvalid)
    else $error("read not answered");
  a_pm_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && flag_a_r && en_a_r |=> pm_event_irq_flag)
    else $error("event interrupt missed");
endmodule : pmc_ctrl
`default_nettype wire

// file: dv/pmc_host_model.sv
// Host controller model issuing register strobes
`timescale 1ns/100ps
`default_nettype none

module pmc_host_model (
  input wire logic sys_clk,
  output pmc_pkg::pmc_req_type host_req,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid
);
  import pmc_pkg::*;

  initial
  begin
    host_req = '0;
  end

  // One strobe, falling edge to falling edge; idle address and data scrambled
  task automatic access(input logic wr, input logic [11:0] addr,
    input logic [31:0] wdata, input logic [3:0] be,
    output logic [31:0] rdata);
    int n;
    rdata = 32'hX;
    @(negedge sys_clk);
    host_req = '{wr, ~wr, addr, wdata, be};
    @(negedge sys_clk);
    host_req.wr = 1'b0;
    host_req.rd = 1'b0;
    host_req.addr = ~addr;
    host_req.wdata = ~wdata;
    for (n = 0; n < 3 && !wr; n++)
    begin
      if (host_rvalid === 1'b1)
      begin
        rdata = host_rdata;
        break;
      end
      @(negedge sys_clk);
    end
  endtask : access
endmodule : pmc_host_model

`default_nettype wire

// file: dv/pmc_ctrl_bench.sv
// Testbench for the power management control register
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_ctrl_bench;
  import pmc_pkg::*;
  logic sys_clk, rst_b, pll_locked, port_a_event, port_b_event, ready_ok;
  logic clk_en;
  logic [1:0] led_level, led_out, led_oe;
  logic [31:0] host_rdata;
  logic host_rvalid, pm_event_irq_flag, ready_irq_flag;
  pmc_req_type host_req;
  pmc_stat_type status;
  int n_errors = 0;
  int comparisons = 0;
  int k;

  pmc_ctrl #(.WAKE_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(clk_en), .host_req(host_req), .pll_locked(pll_locked),
    .port_a_event(port_a_event), .port_b_event(port_b_event),
    .ready_ok(ready_ok), .led_level(led_level), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .status(status),
    .pm_event_irq_flag(pm_event_irq_flag),
    .ready_irq_flag(ready_irq_flag), .led_out(led_out), .led_oe(led_oe));

  pmc_host_model host (.sys_clk(sys_clk), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("Counts: %0d compared, %0d wrong", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [31:0] d);
    logic [31:0] x;
    host.access(1'b1, `PMC_OFFSET, d, 4'hF, x);
  endtask : wr

  task automatic rdc(input string what, input logic [31:0] exp,
    input logic [3:0] be = 4'hF, input logic [11:0] a = `PMC_OFFSET);
    logic [31:0] x;
    host.access(1'b0, a, 32'h00000000, be, x);
    check(what, x, exp);
  endtask : rdc

  // Event on port p, enable en; clears only once source drops
  task automatic flag_test(input logic p, input logic en);
    logic [31:0] e;
    e = {14'h0, p, !p, en && p, en && !p, 13'h0, 1'b1};
    wr({16'h0, en && p, en && !p, 14'h0});
    if (p) port_b_event = 1'b1; else port_a_event = 1'b1;
    repeat (8) @(negedge sys_clk);
    check("event irq", pm_event_irq_flag, en);
    wr(e);
    rdc("flag held", e);
    port_a_event = 1'b0;
    port_b_event = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr(e);
    rdc("flag cleared", e & 32'hFFFCFFFF);
    check("irq cleared", pm_event_irq_flag, 1'b0);
  endtask : flag_test

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end

  initial
  begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    pll_locked = 1'b1;
    port_a_event = 1'b0;
    port_b_event = 1'b0;
    ready_ok = 1'b1;
    led_level = 2'b10;
    repeat (5) @(negedge sys_clk);
    check("status in reset", status, '0);
    rst_b = 1'b1;
    rdc("reset value", 32'h00000001);
    rdc("unmapped", 32'hX, 4'hF, 12'h088);
    $display("test reset done");
    wr(32'hEC3FFFFF);
    rdc("fields once", 32'hEC00C001);
    check("led oe off", led_oe, 2'b00);
    check("led out off", led_out, 2'b00);
    check("led status", status.indicator_output_off, 1'b1);
    wr(32'hEC3FFFFF);
    rdc("fields twice", 32'hEC20C001);
    check("core clock", status.fieldbus_core_clock_off, 1'b1);
    wr(32'h00000000);
    wr(32'h00200000);
    wr(32'h00000000);
    wr(32'h00200000);
    rdc("count restart", 32'h00000001);
    check("core clock on", status.fieldbus_core_clock_off, 1'b0);
    check("led oe on", led_oe, 2'b11);
    check("led out on", led_out, led_level);
    $display("test fields done");
    wr(32'h20000000);
    rdc("byte 0", 32'h00000001, 4'h1);
    rdc("byte 3", 32'h20000000, 4'h8);
    wr(32'h50000000);
    rdc("joint write", 32'h20000001);
    check("no sleep", status.asleep, 1'b0);
    wr(32'hA0000000);
    wr(32'hB0000000);
    rdc("reserved code", 32'hA0000001);
    check("reserved awake", status.asleep, 1'b0);
    $display("test interlock done");
    wr(32'h40000000);
    wr(32'h50000000);
    @(negedge sys_clk);
    check("asleep", status.asleep, 1'b1);
    check("ready low", status.ready, 1'b0);
    check("held state", status.sleep_state_select, 3'h2);
    rdc("sleep read", 32'h50000000);
    for (k = 0; k < 40 && ready_irq_flag !== 1'b1; k++)
      @(negedge sys_clk);
    check("ready irq", ready_irq_flag, 1'b1);
    @(negedge sys_clk);
    check("ready back", status.ready, 1'b1);
    check("irq pulse", ready_irq_flag, 1'b0);
    rdc("woken", 32'h00000001);
    $display("test sleep done");
    // Automatic wake on an enabled port A event
    wr(32'h28004000);
    wr(32'h38004000);
    @(negedge sys_clk);
    check("auto asleep", status.asleep, 1'b1);
    port_a_event = 1'b1;
    for (k = 0; k < 40 && status.ready !== 1'b1; k++)
      @(negedge sys_clk);
    rdc("auto woken", 32'h08014001);
    port_a_event = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr(32'h00010000);
    rdc("auto cleared", 32'h00000001);
    $display("test auto wake done");
    flag_test(1'b0, 1'b1);
    flag_test(1'b1, 1'b0);
    flag_test(1'b1, 1'b1);
    $display("test events done");
    // Clock enable low freezes all state
    clk_en = 1'b0;
    wr(32'h60000000);
    clk_en = 1'b1;
    rdc("frozen", 32'h00008001);
    $display("test freeze done");
    stop_test();
  end
endmodule : pmc_ctrl_bench

`default_nettype wire
